// ### hw/isb_defines.svh
// Constants shared by both ends of the ISA slave port.
// Assumes a 250 MHz core clock on each end.
`ifndef ISB_DEFINES_SVH
`define ISB_DEFINES_SVH

// Device register window and indices
`define ISB_IO_BASE      16'h0300
`define ISB_MEM_BASE     20'hd0000
`define ISB_REG_BUS_CONTROL_REG   3'h5
`define ISB_REG_ISQ      3'h6
`define ISB_REG_CFG      3'h7
`define ISB_REG_RST      16'h0000
// Bus control and configuration fields
`define ISB_BC_WSDIS     8
`define ISB_BC_MEMEN     10
`define ISB_CFG_MEMMODE  4
// Timing
`define ISB_CLK_NS       4
`define ISB_RST_QUAL_NS  400
`define ISB_RST_QUAL_CYC ((`ISB_RST_QUAL_NS + `ISB_CLK_NS - 1) / `ISB_CLK_NS)
`define ISB_RD_WAIT      4'h3
`define ISB_H_RST_HOLD   (`ISB_RST_QUAL_CYC + 8)
`define ISB_H_SETUP      8'h02
`define ISB_H_GUARD      8'h08
// Host controller register offsets
`define ISB_H_CTRL       8'h00
`define ISB_H_ADDR       8'h04
`define ISB_H_WDATA      8'h08
`define ISB_H_RDATA      8'h0c
`define ISB_H_STATUS     8'h10
`define ISB_H_CFG        8'h14

`endif

// ### hw/isb_pkg.sv
// Types shared by both ends of the ISA slave port.
// Assumes isb_defines.svh holds the numeric constants.
package isb_pkg;
  typedef logic [15:0] isb_word_t;
  typedef enum logic [2:0] {
    ISB_CMD_IOR, ISB_CMD_IOW, ISB_CMD_MEMR, ISB_CMD_MEMW,
    ISB_CMD_DMARD, ISB_CMD_RESET, ISB_CMD_REFRESH
  } isb_cmd_t;
endpackage : isb_pkg

// ### hw/isb_if.sv
// ISA bus pins between the host end and the device end.
// Resolves three-state and open-drain wires from output enables.
interface isb_if;
  logic [19:0] sa;
  logic [15:0] sd_host;
  logic        sd_host_oe;
  logic        ior_n, iow_n, memr_n, memw_n;
  logic        aen, refresh_n, sbhe_n, reset, test_n;
  logic        latched_address_select_n;
  logic [2:0]  dma_acknowledge_in_n;
  logic [15:0] sd_dev;
  logic        sd_dev_oe;
  logic        iocs16_oe, memcs16_oe, chrdy_oe;
  logic [3:0]  interrupt_request_out, interrupt_request_oe;
  logic [2:0]  dma_request_out, dma_request_oe;
  // Resolved wire levels, pulled up or down when undriven
  logic [15:0] sd;
  logic        iocs16_n, memcs16_n, chrdy;
  logic [3:0]  irq_level;
  logic [2:0]  drq_level;

  assign sd = sd_dev_oe ? sd_dev : (sd_host_oe ? sd_host : 16'hffff);
  assign iocs16_n  = ~iocs16_oe;
  assign memcs16_n = ~memcs16_oe;
  assign chrdy     = ~chrdy_oe;
  assign irq_level = interrupt_request_out & interrupt_request_oe;
  assign drq_level = dma_request_out & dma_request_oe;

  modport dev (
    input  sa, sd, ior_n, iow_n, memr_n, memw_n, aen, refresh_n, sbhe_n,
           reset, test_n, latched_address_select_n, dma_acknowledge_in_n,
    output sd_dev, sd_dev_oe, iocs16_oe, memcs16_oe, chrdy_oe,
           interrupt_request_out, interrupt_request_oe,
           dma_request_out, dma_request_oe
  );
  modport host (
    output sa, sd_host, sd_host_oe, ior_n, iow_n, memr_n, memw_n, aen,
           refresh_n, sbhe_n, reset, test_n, latched_address_select_n,
           dma_acknowledge_in_n,
    input  sd, iocs16_n, memcs16_n, chrdy, irq_level, drq_level
  );
endinterface : isb_if

// ### hw/isb_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes a synchronous active-high reset on the same clock.
module isb_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RV;
      q_o  <= RV;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : isb_sync

// ### hw/isb_dev.sv
// Device end of the ISA slave port: decode, registers, strobes, requests.
// Assumes the host end drives the pins of isb_if with its modport.
//
// How it works
// - I/O decode SA0-15, memory SA0-19 plus select
// - 16-bit data bus, driven only for reads
// - Reset pin valid after 400 ns held
// - Address enable high blocks I/O cycles
// - Test low makes address enable scan clock
// - Host: enable low for access, high DMA
// - Separate memory read and write strobes
// - Memory select only in enabled memory mode
// - Refresh low masks all strobes and acknowledges
// - I/O read drives addressed register word
// - I/O write captures bus into register
// - I/O select low inside I/O window
// - Ready stretch reads unless wait disable set
// - Byte high enable marks upper byte lanes
// - Host toggles byte high enable after reset
// - Interrupt held until queue reads zero
// - Only selected interrupt output is driven
// - Only selected DMA request output is driven
// - Host acknowledges on the paired input
// - Memory select input ignored outside memory cycles
`include "isb_defines.svh"
module isb_dev
  import isb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  isb_if.dev               bus,
  input  wire logic [15:0] irq_event_i,
  input  wire logic        dma_req_i,
  input  wire isb_word_t   dma_data_i,
  output logic             dma_taken_o,
  output logic             scan_shift_o,
  output logic             pin_reset_o
);
  logic [11:0] s_ctl;
  logic [36:0] s_dat;
  logic        s_reset, s_aen, s_ior_n, s_iow_n, s_memr_n, s_memw_n;
  logic        s_refresh_n, s_test_n, s_lasel_n, s_sbhe_n;
  logic [2:0]  s_dack_n;
  logic [19:0] s_sa;
  isb_word_t   s_sd;
  logic [7:0]  qcnt;
  logic        irst, scan, io_hit, mem_hit, io_rd, io_wr, mem_rd, mem_wr;
  logic        rd, wr, rd_q, wr_q, dma_rd, dma_rd_q, aen_q, lo, hi;
  logic [2:0]  idx;
  isb_word_t   regs [8];
  isb_word_t   interrupt_status_queue, rdata, dma_word;
  logic        irq_pend, dma_pend, memen, wsdis, memmode;
  logic [1:0]  irq_sel, dma_sel;
  logic [3:0]  wcnt;
  genvar       gi;

  // Control pins and address/data pins through two flops
  isb_sync #(.W(12), .RV(12'h3ff)) u_sync_ctl (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.reset, bus.aen, bus.ior_n, bus.iow_n, bus.memr_n,
             bus.memw_n, bus.refresh_n, bus.test_n,
             bus.latched_address_select_n, bus.dma_acknowledge_in_n}),
    .q_o   (s_ctl)
  );
  isb_sync #(.W(37), .RV(37'h1000000000)) u_sync_dat (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.sbhe_n, bus.sa, bus.sd}),
    .q_o   (s_dat)
  );
  assign {s_reset, s_aen, s_ior_n, s_iow_n, s_memr_n, s_memw_n,
          s_refresh_n, s_test_n, s_lasel_n, s_dack_n} = s_ctl;
  assign {s_sbhe_n, s_sa, s_sd} = s_dat;

  // Reset pin must stay high for the full qualification count
  always_ff @(posedge clk_i) begin
    if (rst_i || !s_reset) begin
      qcnt        <= 8'h00;
      pin_reset_o <= 1'b0;
    end else begin
      if (qcnt != 8'(`ISB_RST_QUAL_CYC)) begin
        qcnt <= qcnt + 8'h01;
      end
      pin_reset_o <= (qcnt == 8'(`ISB_RST_QUAL_CYC));
    end
  end
  assign irst = rst_i | pin_reset_o;

  // Configuration fields
  assign memen   = regs[`ISB_REG_BUS_CONTROL_REG][`ISB_BC_MEMEN];
  assign wsdis   = regs[`ISB_REG_BUS_CONTROL_REG][`ISB_BC_WSDIS];
  assign memmode = regs[`ISB_REG_CFG][`ISB_CFG_MEMMODE];
  assign irq_sel = regs[`ISB_REG_CFG][1:0];
  assign dma_sel = regs[`ISB_REG_CFG][3:2];

  // Address decode and strobe qualification
  assign scan    = ~s_test_n;
  assign io_hit  = ~scan & ~s_aen
                 & (s_sa[15:4] == `ISB_IO_BASE >> 4);
  assign mem_hit = ~scan & memmode & memen & ~s_lasel_n
                 & (s_sa[19:4] == `ISB_MEM_BASE >> 4);
  assign io_rd   = io_hit & ~s_ior_n & s_refresh_n;
  assign io_wr   = io_hit & ~s_iow_n & s_refresh_n;
  assign mem_rd  = mem_hit & ~s_memr_n & s_refresh_n;
  assign mem_wr  = mem_hit & ~s_memw_n & s_refresh_n;
  assign dma_rd  = ~scan & s_aen & s_refresh_n & ~s_ior_n
                 & ~s_dack_n[dma_sel] & (dma_sel != 2'h3);
  assign rd      = io_rd | mem_rd;
  assign wr      = io_wr | mem_wr;
  assign idx     = s_sa[3:1];
  assign lo      = ~s_sa[0];
  assign hi      = ~s_sbhe_n;

  // Strobe edge history
  always_ff @(posedge clk_i) begin
    if (irst) begin
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      dma_rd_q <= 1'b0;
      aen_q    <= 1'b0;
    end else begin
      rd_q     <= rd;
      wr_q     <= wr;
      dma_rd_q <= dma_rd;
      aen_q    <= s_aen;
    end
  end

  // Register file, one write per strobe, per byte lane
  for (gi = 0; gi < 8; gi++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (irst) begin
        regs[gi] <= `ISB_REG_RST;
      end else if (wr && !wr_q && idx == 3'(gi)
                   && 3'(gi) != `ISB_REG_ISQ) begin
        if (lo) begin
          regs[gi][7:0] <= s_sd[7:0];
        end
        if (hi) begin
          regs[gi][15:8] <= s_sd[15:8];
        end
      end
    end
  end

  // Interrupt queue: events set, reading clears what was returned
  always_ff @(posedge clk_i) begin
    if (irst) begin
      interrupt_status_queue      <= 16'h0000;
      irq_pend <= 1'b0;
    end else begin
      if (rd && !rd_q && idx == `ISB_REG_ISQ) begin
        interrupt_status_queue <= irq_event_i; // Set wins over the clear
      end else begin
        interrupt_status_queue <= interrupt_status_queue | irq_event_i;
      end
      if (|interrupt_status_queue || |irq_event_i) begin
        irq_pend <= 1'b1;
      end else if (rd && !rd_q && idx == `ISB_REG_ISQ) begin
        irq_pend <= 1'b0;
      end
    end
  end

  // Read data latched at strobe start, driven until strobe leaves
  always_ff @(posedge clk_i) begin
    if (irst) begin
      rdata         <= 16'h0000;
      bus.sd_dev_oe <= 1'b0;
    end else begin
      if (dma_rd && !dma_rd_q) begin
        rdata <= dma_word;
      end else if (rd && !rd_q) begin
        rdata <= (idx == `ISB_REG_ISQ) ? interrupt_status_queue : regs[idx];
      end
      bus.sd_dev_oe <= rd | dma_rd;
    end
  end
  assign bus.sd_dev = rdata;

  // Ready stretch for I/O and memory reads
  always_ff @(posedge clk_i) begin
    if (irst) begin
      wcnt         <= 4'h0;
      bus.chrdy_oe <= 1'b0;
    end else if (rd && !rd_q && !wsdis) begin
      wcnt         <= `ISB_RD_WAIT;
      bus.chrdy_oe <= 1'b1;
    end else if (wcnt != 4'h0 && rd) begin
      wcnt <= wcnt - 4'h1;
    end else begin
      wcnt         <= 4'h0;
      bus.chrdy_oe <= 1'b0;
    end
  end

  // Select outputs, open-drain
  always_ff @(posedge clk_i) begin
    if (irst) begin
      bus.iocs16_oe  <= 1'b0;
      bus.memcs16_oe <= 1'b0;
    end else begin
      bus.iocs16_oe  <= io_hit;
      bus.memcs16_oe <= mem_hit;
    end
  end

  // DMA word held until the host controller takes it
  always_ff @(posedge clk_i) begin
    if (irst) begin
      dma_pend    <= 1'b0;
      dma_word    <= 16'h0000;
      dma_taken_o <= 1'b0;
    end else begin
      dma_taken_o <= dma_rd && !dma_rd_q && dma_pend;
      if (dma_req_i && !dma_pend) begin
        dma_pend <= 1'b1;
        dma_word <= dma_data_i;
      end else if (dma_rd && !dma_rd_q) begin
        dma_pend <= 1'b0;
      end
    end
  end

  // Request outputs: only the selected line leaves high impedance
  for (gi = 0; gi < 4; gi++) begin : g_req
    always_ff @(posedge clk_i) begin
      if (irst) begin
        bus.interrupt_request_out[gi] <= 1'b0;
        bus.interrupt_request_oe[gi]  <= 1'b0;
      end else begin
        bus.interrupt_request_out[gi] <= irq_pend && irq_sel == 2'(gi);
        bus.interrupt_request_oe[gi]  <= (irq_sel == 2'(gi));
      end
    end
    if (gi < 3) begin : g_drq
      always_ff @(posedge clk_i) begin
        if (irst) begin
          bus.dma_request_out[gi] <= 1'b0;
          bus.dma_request_oe[gi]  <= 1'b0;
        end else begin
          bus.dma_request_out[gi] <= dma_pend && dma_sel == 2'(gi);
          bus.dma_request_oe[gi]  <= (dma_sel == 2'(gi));
        end
      end
    end
  end

  // Scan clock pulse from address enable in test mode
  always_ff @(posedge clk_i) begin
    if (irst) begin
      scan_shift_o <= 1'b0;
    end else begin
      scan_shift_o <= scan && s_aen && !aen_q;
    end
  end
endmodule : isb_dev

// ### hw/isb_host.sv
// Host end: AHB-Lite register slave that runs ISA cycles on isb_if.
// Assumes one AHB master; answers every transfer with zero wait.
`include "isb_defines.svh"
module isb_host
  import isb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  isb_if.host              bus
);
  typedef enum {ST_RST, ST_TOG_LO, ST_TOG_HI, ST_IDLE, ST_SETUP,
                ST_STROBE, ST_WAIT, ST_HOLD} isb_hstate_t;
  isb_hstate_t state;
  isb_cmd_t    cmd;
  logic [19:0] addr;
  logic [16:0] wdata;
  isb_word_t   rdata;
  logic        test_n, done, a_wr, go;
  logic [7:0]  a_addr, cnt;
  logic [24:0] s_in;
  isb_word_t   s_sd;
  logic        s_chrdy;
  logic [3:0]  s_irq;
  logic [2:0]  s_drq;
  logic        s_cs;
  logic        is_dma, is_mem, strobe;

  // Device pins through two flops
  isb_sync #(.W(25), .RV(25'h1000000)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({bus.chrdy, bus.irq_level, bus.drq_level,
             bus.iocs16_n & bus.memcs16_n, bus.sd}),
    .q_o   (s_in)
  );
  assign {s_chrdy, s_irq, s_drq, s_cs, s_sd} = s_in;

  // AHB address phase capture and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_wr     <= 1'b0;
      a_addr   <= 8'h00;
      hrdata_o <= 32'h00000000;
    end else begin
      a_wr   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      a_addr <= haddr_i[7:0];
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
        if (haddr_i[7:0] == `ISB_H_ADDR) begin
          hrdata_o <= {12'h000, addr};
        end else if (haddr_i[7:0] == `ISB_H_WDATA) begin
          hrdata_o <= {15'h0000, wdata};
        end else if (haddr_i[7:0] == `ISB_H_RDATA) begin
          hrdata_o <= {16'h0000, rdata};
        end else if (haddr_i[7:0] == `ISB_H_STATUS) begin
          hrdata_o <= {21'h000000, ~s_cs, s_drq, s_irq, s_chrdy,
                       done, state != ST_IDLE};
        end else if (haddr_i[7:0] == `ISB_H_CFG) begin
          hrdata_o <= {31'h00000000, test_n};
        end else begin
          hrdata_o <= 32'h00000000;
        end
      end
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign go = a_wr && a_addr == `ISB_H_CTRL && state == ST_IDLE;

  // Software registers; a new command clears done unless one ends now
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr   <= 20'h00000;
      wdata  <= 17'h10000;
      test_n <= 1'b1;
      cmd    <= ISB_CMD_IOR;
      done   <= 1'b0;
    end else begin
      if (a_wr && a_addr == `ISB_H_ADDR) begin
        addr <= hwdata_i[19:0];
      end
      if (a_wr && a_addr == `ISB_H_WDATA) begin
        wdata <= hwdata_i[16:0];
      end
      if (a_wr && a_addr == `ISB_H_CFG) begin
        test_n <= hwdata_i[0];
      end
      if (go) begin
        cmd <= isb_cmd_t'(hwdata_i[2:0]);
      end
      // A reset command ends after the byte high toggle, not in HOLD
      if ((state == ST_HOLD || state == ST_TOG_HI) && cnt == 8'h00) begin
        done <= 1'b1;
      end else if (go) begin
        done <= 1'b0;
      end
    end
  end

  assign is_dma = (cmd == ISB_CMD_DMARD);
  assign is_mem = (cmd == ISB_CMD_MEMR) || (cmd == ISB_CMD_MEMW)
               || (cmd == ISB_CMD_REFRESH);
  assign strobe = (state == ST_STROBE) || (state == ST_WAIT);

  // Cycle sequencer: reset pulse, byte high toggle, then bus cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RST;
      cnt   <= 8'(`ISB_H_RST_HOLD);
      rdata <= 16'h0000;
    end else begin
      case (state)
        ST_RST: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= ST_TOG_LO;
            cnt   <= `ISB_H_SETUP;
          end
        end
        ST_TOG_LO, ST_TOG_HI: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= (state == ST_TOG_LO) ? ST_TOG_HI : ST_IDLE;
            cnt   <= `ISB_H_SETUP;
          end
        end
        ST_IDLE: begin
          if (go && hwdata_i[2:0] == 3'(ISB_CMD_RESET)) begin
            state <= ST_RST;
            cnt   <= 8'(`ISB_H_RST_HOLD);
          end else if (go) begin
            state <= ST_SETUP;
            cnt   <= `ISB_H_SETUP;
          end
        end
        ST_SETUP: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= ST_STROBE;
            cnt   <= `ISB_H_GUARD;
          end
        end
        ST_STROBE: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (s_chrdy) begin
            rdata <= s_sd;
            state <= ST_HOLD;
            cnt   <= `ISB_H_SETUP;
          end
        end
        ST_HOLD: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive from the sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.sa                       <= 20'h00000;
      bus.sd_host                  <= 16'h0000;
      bus.sd_host_oe               <= 1'b0;
      bus.ior_n                    <= 1'b1;
      bus.iow_n                    <= 1'b1;
      bus.memr_n                   <= 1'b1;
      bus.memw_n                   <= 1'b1;
      bus.aen                      <= 1'b0;
      bus.refresh_n                <= 1'b1;
      bus.sbhe_n                   <= 1'b1;
      bus.reset                    <= 1'b0;
      bus.test_n                   <= 1'b1;
      bus.latched_address_select_n <= 1'b1;
      bus.dma_acknowledge_in_n     <= 3'h7;
    end else begin
      bus.test_n  <= test_n;
      bus.reset   <= (state == ST_RST);
      bus.sa      <= addr;
      bus.sd_host <= wdata[15:0];
      if (state == ST_TOG_LO) begin
        bus.sbhe_n <= 1'b0;
      end else if (state == ST_SETUP || state == ST_STROBE
                   || state == ST_WAIT || state == ST_HOLD) begin
        bus.sbhe_n <= wdata[16];
      end else begin
        bus.sbhe_n <= 1'b1;
      end
      if (state == ST_SETUP || strobe || state == ST_HOLD) begin
        bus.aen <= is_dma;
        bus.latched_address_select_n <=
          ~(is_mem && addr[19:4] == `ISB_MEM_BASE >> 4);
        bus.dma_acknowledge_in_n <=
          is_dma ? ~(3'h1 << addr[1:0]) : 3'h7;
        bus.sd_host_oe <= (cmd == ISB_CMD_IOW) || (cmd == ISB_CMD_MEMW);
      end else begin
        bus.aen                      <= 1'b0;
        bus.latched_address_select_n <= 1'b1;
        bus.dma_acknowledge_in_n     <= 3'h7;
        bus.sd_host_oe               <= 1'b0;
      end
      bus.ior_n     <= ~(strobe && (cmd == ISB_CMD_IOR || is_dma));
      bus.iow_n     <= ~(strobe && cmd == ISB_CMD_IOW);
      bus.memr_n    <= ~(strobe && (cmd == ISB_CMD_MEMR
                                    || cmd == ISB_CMD_REFRESH));
      bus.memw_n    <= ~(strobe && cmd == ISB_CMD_MEMW);
      bus.refresh_n <= ~(strobe && cmd == ISB_CMD_REFRESH);
    end
  end
endmodule : isb_host

// ### verif/isb_checker.sv
// Checker for the ISA pins between the host end and the device end.
// Assumes its inputs are wired by name to the signals of isb_if.
module isb_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [19:0] sa,
  input wire logic        ior_n,
  input wire logic        memr_n,
  input wire logic        aen,
  input wire logic        refresh_n,
  input wire logic        test_n,
  input wire logic [2:0]  dma_acknowledge_in_n,
  input wire logic        sd_dev_oe,
  input wire logic        iocs16_oe,
  input wire logic        memcs16_oe,
  input wire logic        chrdy_oe,
  input wire logic [3:0]  interrupt_request_oe,
  input wire logic [2:0]  dma_request_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Pin drivers and their causes
  a_irq_one_line: assert property ($onehot0(interrupt_request_oe))
    else $error("more than one interrupt line driven");
  a_drq_one_line: assert property ($onehot0(dma_request_oe))
    else $error("more than one DMA request line driven");
  a_data_on_read: assert property ($rose(sd_dev_oe) |->
    !$past(ior_n & memr_n, 3)) else $error("data driven without read");
  a_data_release: assert property ($rose(ior_n & memr_n) |->
    ##[1:5] !sd_dev_oe) else $error("data bus not released");
  a_refresh_mask: assert property ($rose(sd_dev_oe) |->
    $past(refresh_n, 3)) else $error("read answered during refresh");
  a_aen_blocks_io: assert property ($rose(sd_dev_oe) |->
    !$past(aen, 3) || $past(dma_acknowledge_in_n, 3) != 3'h7)
    else $error("I/O read answered with address enable high");
  a_test_blocks: assert property ($rose(sd_dev_oe) |->
    $past(test_n, 3)) else $error("read answered in scan mode");
  a_io_window: assert property (iocs16_oe |->
    $past(sa[15:4], 3) == 12'h030) else $error("I/O select outside window");
  a_mem_window: assert property (memcs16_oe |->
    $past(sa[19:4], 3) == 16'hd000) else $error("memory select outside");
  a_ready_bound: assert property ($rose(chrdy_oe) |->
    sd_dev_oe ##[1:6] !chrdy_oe) else $error("ready stretch unbounded");

  // Main scenarios
  c_read: cover property ($rose(sd_dev_oe));
  c_stretch: cover property ($rose(chrdy_oe));
  c_mem: cover property (memcs16_oe);
  c_irq: cover property (interrupt_request_oe != 4'h0);
  c_drq: cover property (dma_request_oe != 3'h0);
endmodule : isb_checker

// ### verif/isa_slave_bus_port_bench.sv
// Bench: AHB-Lite calls into the host end run ISA cycles on the device.
// Assumes the host end answers with zero wait and reports done in STATUS.
`include "isb_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module isa_slave_bus_port_bench
  import isb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, hsel, hwrite, hrdy, hresp, taken, scan, prst;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [15:0] irq_ev, dma_d, r;
  logic        dma_rq;
  int          n_errors, num_checks, n_chrdy, n_scan, n_prst, n_taken;
  isb_if bus();
  isb_dev i_isb_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .irq_event_i(irq_ev), .dma_req_i(dma_rq), .dma_data_i(dma_d),
    .dma_taken_o(taken), .scan_shift_o(scan), .pin_reset_o(prst));
  isb_host i_isb_host (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .bus(bus));
  isb_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .sa(bus.sa),
    .ior_n(bus.ior_n), .memr_n(bus.memr_n), .aen(bus.aen),
    .refresh_n(bus.refresh_n), .test_n(bus.test_n),
    .dma_acknowledge_in_n(bus.dma_acknowledge_in_n),
    .sd_dev_oe(bus.sd_dev_oe), .iocs16_oe(bus.iocs16_oe),
    .memcs16_oe(bus.memcs16_oe), .chrdy_oe(bus.chrdy_oe),
    .interrupt_request_oe(bus.interrupt_request_oe),
    .dma_request_oe(bus.dma_request_oe));

  // Clock at 4 ns
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  // Event counters watched by the tests
  always @(posedge clk_i) begin
    n_chrdy += int'(bus.chrdy_oe === 1'b1);
    n_scan += int'(scan === 1'b1);
    n_prst += int'(prst === 1'b1);
    n_taken += int'(taken === 1'b1);
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // One single AHB transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel <= 1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
    do @(posedge clk_i); while (hrdy !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // One ISA cycle through the host end, waiting for done
  task automatic cmd(input isb_cmd_t op, input logic [19:0] a,
                     input logic [16:0] d, output logic [15:0] rd);
    logic [31:0] s;
    int n;
    ahb(1, `ISB_H_ADDR, {12'h0, a}, s);
    ahb(1, `ISB_H_WDATA, {15'h0, d}, s);
    ahb(1, `ISB_H_CTRL, {29'h0, op}, s);
    n = 0;
    do begin ahb(0, `ISB_H_STATUS, 0, s); n++; end
    while (s[1] !== 1'b1 && n < 400);
    if (n >= 400) n_errors++;
    ahb(0, `ISB_H_RDATA, 0, s);
    rd = s[15:0];
  endtask : cmd

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    summarize();
  end

  // Test sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, irq_ev, dma_rq, dma_d} = '0;
    n_errors = 0; num_checks = 0; rst_i = 1;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    repeat (150) @(posedge clk_i);
    cmd(ISB_CMD_IOW, 20'h0030a, 16'h0400, r);
    n_chrdy = 0;
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("bc", 16'h0400, r)
    `CHK("stretch", 1'b1, n_chrdy > 0)
    cmd(ISB_CMD_IOW, 20'h0030e, 16'h0014, r);
    cmd(ISB_CMD_IOR, 20'h0030e, 0, r); `CHK("cfg", 16'h0014, r)
    cmd(ISB_CMD_REFRESH, 20'hd000a, 0, r); `CHK("rfshm", 16'hffff, r)
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("rfsh", 16'h0400, r)
    $display("test io done");
    cmd(ISB_CMD_IOR, 20'h00320, 0, r); `CHK("miss", 16'hffff, r)
    cmd(ISB_CMD_IOR, 20'h1030a, 0, r); `CHK("sa16", 16'h0400, r)
    cmd(ISB_CMD_MEMR, 20'hd000a, 0, r); `CHK("memr", 16'h0400, r)
    cmd(ISB_CMD_MEMW, 20'hd000a, 16'h0500, r);
    n_chrdy = 0;
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("memw", 16'h0500, r)
    `CHK("nowait", 1'b0, n_chrdy > 0)
    cmd(ISB_CMD_IOW, 20'h0030a, 16'h0000, r);
    cmd(ISB_CMD_MEMR, 20'hd000a, 0, r); `CHK("memoff", 16'hffff, r)
    $display("test decode done");
    @(posedge clk_i) irq_ev <= 16'h0005;
    @(posedge clk_i) irq_ev <= 16'h0000;
    repeat (6) @(posedge clk_i);
    ahb(0, `ISB_H_STATUS, 0, x); `CHK("irq", 4'h1, x[6:3])
    cmd(ISB_CMD_IOR, 20'h0030c, 0, r); `CHK("isq", 16'h0005, r)
    ahb(0, `ISB_H_STATUS, 0, x); `CHK("irqheld", 4'h1, x[6:3])
    cmd(ISB_CMD_IOR, 20'h0030c, 0, r); `CHK("isq0", 16'h0000, r)
    ahb(0, `ISB_H_STATUS, 0, x); `CHK("irqlow", 4'h0, x[6:3])
    $display("test irq done");
    @(posedge clk_i) begin dma_rq <= 1; dma_d <= 16'hbeef; end
    @(posedge clk_i) dma_rq <= 0;
    repeat (6) @(posedge clk_i);
    ahb(0, `ISB_H_STATUS, 0, x); `CHK("drq", 3'b010, x[9:7])
    cmd(ISB_CMD_DMARD, 20'h0030a, 0, r); `CHK("dack2", 16'hffff, r)
    cmd(ISB_CMD_DMARD, 20'h1, 0, r); `CHK("dack1", 16'hbeef, r)
    `CHK("taken", 1, n_taken)
    ahb(0, `ISB_H_STATUS, 0, x); `CHK("drq0", 3'b000, x[9:7])
    $display("test dma done");
    ahb(1, `ISB_H_CFG, 0, x);
    n_scan = 0;
    cmd(ISB_CMD_DMARD, 20'h1, 0, r); `CHK("scan", 1, n_scan)
    ahb(1, `ISB_H_CFG, 1, x);
    cmd(ISB_CMD_IOW, 20'h0030a, 16'h0400, r);
    n_prst = 0;
    cmd(ISB_CMD_RESET, 20'h0, 0, r); `CHK("prst", 1'b1, n_prst > 0)
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("rst", `ISB_REG_RST, r)
    $display("test reset done");
    cmd(ISB_CMD_IOW, 20'h0030a, 17'h1abcd, r);
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("lane_lo", 16'h00cd, r)
    cmd(ISB_CMD_IOW, 20'h0030b, 17'h0ef00, r);
    cmd(ISB_CMD_IOR, 20'h0030a, 0, r); `CHK("lane_hi", 16'hefcd, r)
    $display("test lanes done");
    summarize();
  end
endmodule : isa_slave_bus_port_bench
